// File: scc_pkg.sv
// Package: constants, types and timing figures for the stepper chopper control block
package scc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SLEEP_OFF_NS = 2500;
    localparam int ENABLE_NS = 20000;
    localparam int RESET_NS = 5000;
    localparam int WAKE_MS = 1;
    localparam int DEAD_NS = 200;
    localparam int BLANK_NS = 2000;
    localparam int OFF_NS = 42000;
    // Longest times round down, least times round up
    localparam int SLEEP_OFF_CYC = SLEEP_OFF_NS / CLK_PERIOD_NS;
    localparam int ENABLE_CYC = ENABLE_NS / CLK_PERIOD_NS;
    localparam int RESET_CYC = RESET_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYC = WAKE_MS * 1000 * CLK_MHZ;
    localparam int DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
    localparam int OFF_CYC = OFF_NS / CLK_PERIOD_NS;
    localparam int FD_CYC = OFF_CYC / 4;
    // Current sense gain
    localparam int SENSE_GAIN_SHIFT = 3;
    localparam int CNT_W = 20;
    localparam int LVL_W = 8;

    // ------------------------------------------------------------------
    // Decay encoding
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCC_DEC_SLOW = 2'h0,
        SCC_DEC_FAST = 2'h1,
        SCC_DEC_MIXED = 2'h2,
        SCC_DEC_AUTO = 2'h3
    } scc_decay_e;

    // Decay-select pin as two threshold comparator outputs
    typedef struct packed {
        logic above_hi;
        logic above_lo;
    } scc_decay_pin_s;

    // Gate drive for one H bridge: high and low switch of both legs
    typedef struct packed {
        logic hs1;
        logic ls1;
        logic hs2;
        logic ls2;
    } scc_gate_s;

    // Per-bridge chopping timing
    typedef struct packed {
        logic [CNT_W-1:0] blank_cyc;
        logic [CNT_W-1:0] off_cyc;
        logic [CNT_W-1:0] fd_cyc;
    } scc_timing_s;

endpackage : scc_pkg

// File: scc_bridge.sv
// Chopper for one H bridge: blanking, off-time, decay and dead time
`timescale 1ns/10ps
module scc_bridge
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic run,
    input wire logic polarity,
    input wire scc_decay_e decay,
    input wire logic sync_rect,
    input wire scc_timing_s timing,
    // Current loop
    input wire logic [LVL_W-1:0] current_sense_in,
    input wire logic [LVL_W-1:0] trip_level,
    input wire logic zero_cross,
    // Gate drive
    output scc_gate_s gate,
    output logic in_off
);

    typedef enum logic [1:0] {
        SCC_ST_IDLE = 2'h0,
        SCC_ST_BLANK = 2'h1,
        SCC_ST_SENSE = 2'h2,
        SCC_ST_OFF = 2'h3
    } scc_phase_e;

    typedef struct packed {
        scc_phase_e phase;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] dead;
        logic stopped;
        logic auto_fast;
        scc_gate_s want;
        scc_gate_s gate;
    } scc_br_state_s;

    scc_br_state_s st_r;
    scc_br_state_s st_nxt;
    logic [LVL_W+SENSE_GAIN_SHIFT-1:0] amp;
    logic tripped;
    logic fast_now;
    logic changed;

    // Sense times eight against the reference
    assign amp = {current_sense_in, {SENSE_GAIN_SHIFT{1'b0}}};
    assign tripped = amp >= {{SENSE_GAIN_SHIFT{1'b0}}, trip_level};

    // Decay choice for the current off-time slice
    always_comb begin
        fast_now = 1'b0;
        case (decay)
            SCC_DEC_FAST: fast_now = 1'b1;
            SCC_DEC_MIXED: fast_now = (st_r.cnt < timing.fd_cyc);
            SCC_DEC_AUTO: fast_now = st_r.auto_fast && (st_r.cnt < timing.fd_cyc);
            default: fast_now = 1'b0;
        endcase
    end

    // Chopping FSM; counter runs up per phase
    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt = st_r.cnt + 20'h00001;
        if (!run) begin
            // Forced off, restarts in drive when released
            st_nxt.phase = SCC_ST_IDLE;
            st_nxt.cnt = '0;
            st_nxt.stopped = 1'b0;
        end else begin
            case (st_r.phase)
                SCC_ST_IDLE: begin
                    st_nxt.phase = SCC_ST_BLANK;
                    st_nxt.cnt = '0;
                end
                SCC_ST_BLANK: begin
                    // Comparator blanked
                    if (st_r.cnt + 20'h00001 >= timing.blank_cyc) begin
                        st_nxt.phase = SCC_ST_SENSE;
                        st_nxt.cnt = '0;
                    end
                end
                SCC_ST_SENSE: begin
                    if (tripped) begin
                        st_nxt.phase = SCC_ST_OFF;
                        st_nxt.cnt = '0;
                        st_nxt.stopped = 1'b0;
                        // Early trip means high ripple: add fast
                        st_nxt.auto_fast = (st_r.cnt < timing.blank_cyc);
                    end
                end
                SCC_ST_OFF: begin
                    if (sync_rect && zero_cross) begin
                        st_nxt.stopped = 1'b1;
                    end
                    if (st_r.cnt + 20'h00001 >= timing.off_cyc) begin
                        st_nxt.phase = SCC_ST_BLANK;
                        st_nxt.cnt = '0;
                        st_nxt.stopped = 1'b0;
                    end
                end
                default: begin
                    st_nxt.phase = SCC_ST_IDLE;
                end
            endcase
        end

        // Wanted switch pattern; polarity high drives 1 to 2
        st_nxt.want = '0;
        if (run && (st_r.phase == SCC_ST_BLANK || st_r.phase == SCC_ST_SENSE)) begin
            st_nxt.want.hs1 = polarity;
            st_nxt.want.ls2 = polarity;
            st_nxt.want.hs2 = !polarity;
            st_nxt.want.ls1 = !polarity;
        end else if (run && st_r.phase == SCC_ST_OFF && !st_r.stopped) begin
            if (fast_now) begin
                // Reverse polarity returns energy to supply
                st_nxt.want.hs2 = polarity && sync_rect;
                st_nxt.want.ls1 = polarity;
                st_nxt.want.hs1 = !polarity && sync_rect;
                st_nxt.want.ls2 = !polarity;
            end else begin
                // Recirculate low; freewheel only when rectifying
                st_nxt.want.ls2 = polarity || sync_rect;
                st_nxt.want.ls1 = !polarity || sync_rect;
            end
        end

        // Dead time after any change; turn-off immediate
        changed = (st_r.want != st_nxt.want);
        if (changed) begin
            st_nxt.dead = '0;
        end else if (st_r.dead < DEAD_CYC[CNT_W-1:0]) begin
            st_nxt.dead = st_r.dead + 20'h00001;
        end
        st_nxt.gate = st_r.gate & st_nxt.want;
        if (!changed && st_r.dead >= DEAD_CYC[CNT_W-1:0]) begin
            st_nxt.gate = st_r.want;
        end
        if (!run) begin
            st_nxt.gate = '0;
        end
    end

    // Registered state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign gate = st_r.gate;
    assign in_off = (st_r.phase == SCC_ST_OFF);

endmodule : scc_bridge

// File: scc_top.sv
// Stepper chopper control: two bridges, control pins timing and registers
//
// Function
// - Steps ignored up to 1 ms after wake.
// - Sleep disables bridges within 2.5 us.
// - Enable pin switches outputs a few cycles after a 20 us settle count.
// - Reset pin switches outputs within 5 us.
// - Slow decay recirculates low; fast reverses.
// - Dead interval before turning on leg partner.
// - Rectification drives freewheel switches on.
// - Rectified decay stops near zero current.
// - Mixed: fast interval then slow remainder.
// - Decay pin decodes slow, fast, mixed.
// - Floating rectification pin selects auto decay.
// - Trip when eight times sense reaches reference.
// - Comparator blanked at each drive start.
// - Fixed off-time after trip, then drive.
// - Each bridge has own timing.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module scc_top
    import scc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int ENABLE_CYCLES = ENABLE_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control pins from the motion controller
    input wire logic sleep_in_n,
    input wire logic output_enable_in_n,
    input wire logic device_reset_in_n,
    input wire logic sync_rect_select_n,
    input wire logic sync_rect_float,
    input wire scc_decay_pin_s decay_pin,
    input wire logic step_in,
    // Per-bridge current loop (A then B)
    input wire logic [LVL_W-1:0] current_sense_in_a,
    input wire logic [LVL_W-1:0] current_sense_in_b,
    input wire logic [LVL_W-1:0] trip_level_a,
    input wire logic [LVL_W-1:0] trip_level_b,
    input wire logic polarity_a,
    input wire logic polarity_b,
    input wire logic zero_cross_a,
    input wire logic zero_cross_b,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Gate drive and step accept
    output scc_gate_s gate_a,
    output scc_gate_s gate_b,
    output logic step_accept
);

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_BLANK_A = 8'h00;
    localparam logic [7:0] ADDR_OFF_A = 8'h04;
    localparam logic [7:0] ADDR_FD_A = 8'h08;
    localparam logic [7:0] ADDR_BLANK_B = 8'h0c;
    localparam logic [7:0] ADDR_OFF_B = 8'h10;
    localparam logic [7:0] ADDR_FD_B = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [CNT_W-1:0] RST_BLANK = BLANK_CYC[CNT_W-1:0];
    localparam logic [CNT_W-1:0] RST_OFF = OFF_CYC[CNT_W-1:0];
    localparam logic [CNT_W-1:0] RST_FD = FD_CYC[CNT_W-1:0];
    localparam logic [CNT_W-1:0] SLEEP_CNT = SLEEP_OFF_CYC[CNT_W-1:0];
    localparam logic [CNT_W-1:0] RESET_CNT = RESET_CYC[CNT_W-1:0];
    localparam logic [CNT_W-1:0] ENABLE_CNT = ENABLE_CYCLES[CNT_W-1:0];
    localparam logic [CNT_W-1:0] WAKE_CNT = WAKE_CYCLES[CNT_W-1:0];

    typedef struct packed {
        // Synchronisers: stage one feeds only stage two
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic step_prev;
        // Pin qualifiers
        logic [CNT_W-1:0] wake_cnt;
        logic [CNT_W-1:0] en_cnt;
        logic enabled;
        logic run;
        logic step_accept;
        // Registers
        scc_timing_s tim_a;
        scc_timing_s tim_b;
        // Bus
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scc_top_state_s;

    scc_top_state_s st_r;
    scc_top_state_s st_nxt;
    logic sleep_n_s;
    logic enable_n_s;
    logic reset_n_s;
    logic sr_n_s;
    logic sr_float_s;
    logic dec_hi_s;
    logic dec_lo_s;
    scc_decay_e decay_sel;
    logic in_off_a;
    logic in_off_b;
    scc_gate_s gate_a_w;
    scc_gate_s gate_b_w;

    // Synchronised pin views, second stage only
    assign sleep_n_s = st_r.sync2[0];
    assign enable_n_s = st_r.sync2[1];
    assign reset_n_s = st_r.sync2[2];
    assign sr_n_s = st_r.sync2[3];
    assign sr_float_s = st_r.sync2[4];
    assign dec_hi_s = st_r.sync2[5];
    assign dec_lo_s = st_r.sync2[6];

    // Decay decode; floating rectify pin wins
    always_comb begin
        if (sr_float_s) begin
            decay_sel = SCC_DEC_AUTO;
        end else if (dec_hi_s) begin
            decay_sel = SCC_DEC_SLOW;
        end else if (!dec_lo_s) begin
            decay_sel = SCC_DEC_FAST;
        end else begin
            decay_sel = SCC_DEC_MIXED;
        end
    end

    // ------------------------------------------------------------------
    // Control pins and AXI4-Lite slave
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] wmask;
        logic [31:0] merged;
        wmask = {{8{st_r.w_strb[3]}}, {8{st_r.w_strb[2]}}, {8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}};
        merged = 32'h00000000;
        st_nxt = st_r;
        st_nxt.sync1 = {decay_pin.above_lo, decay_pin.above_hi, sync_rect_float, sync_rect_select_n,
                        device_reset_in_n, output_enable_in_n, sleep_in_n};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.step_prev = step_in;

        // Enable pin qualified by a settle count equal to the limit
        if (enable_n_s == st_r.enabled) begin
            if (st_r.en_cnt + 20'h00001 >= ENABLE_CNT) begin
                st_nxt.enabled = !enable_n_s;
                st_nxt.en_cnt = '0;
            end else begin
                st_nxt.en_cnt = st_r.en_cnt + 20'h00001;
            end
        end else begin
            st_nxt.en_cnt = '0;
        end
        // Sleep and reset act within a few cycles
        st_nxt.run = sleep_n_s && reset_n_s && st_r.enabled;

        // Steps ignored while waking
        if (!sleep_n_s) begin
            st_nxt.wake_cnt = '0;
        end else if (st_r.wake_cnt < WAKE_CNT) begin
            st_nxt.wake_cnt = st_r.wake_cnt + 20'h00001;
        end
        // Step edge; direction hold is the controller's job
        st_nxt.step_accept = step_in && !st_r.step_prev && sleep_n_s && reset_n_s
                             && (st_r.wake_cnt >= WAKE_CNT);

        // Write: address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            merged = st_r.w_data & wmask;
            case (st_r.aw_addr)
                ADDR_BLANK_A: st_nxt.tim_a.blank_cyc = CNT_W'(({12'h000, st_r.tim_a.blank_cyc} & ~wmask) | merged);
                ADDR_OFF_A: st_nxt.tim_a.off_cyc = CNT_W'(({12'h000, st_r.tim_a.off_cyc} & ~wmask) | merged);
                ADDR_FD_A: st_nxt.tim_a.fd_cyc = CNT_W'(({12'h000, st_r.tim_a.fd_cyc} & ~wmask) | merged);
                ADDR_BLANK_B: st_nxt.tim_b.blank_cyc = CNT_W'(({12'h000, st_r.tim_b.blank_cyc} & ~wmask) | merged);
                ADDR_OFF_B: st_nxt.tim_b.off_cyc = CNT_W'(({12'h000, st_r.tim_b.off_cyc} & ~wmask) | merged);
                ADDR_FD_B: st_nxt.tim_b.fd_cyc = CNT_W'(({12'h000, st_r.tim_b.fd_cyc} & ~wmask) | merged);
                ADDR_STATUS: st_nxt.bresp = RESP_OKAY;
                default: st_nxt.bresp = RESP_SLVERR;
            endcase
        end

        // Read channel: one outstanding read
        if (s_axi_rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_BLANK_A: st_nxt.rdata = {12'h000, st_r.tim_a.blank_cyc};
                ADDR_OFF_A: st_nxt.rdata = {12'h000, st_r.tim_a.off_cyc};
                ADDR_FD_A: st_nxt.rdata = {12'h000, st_r.tim_a.fd_cyc};
                ADDR_BLANK_B: st_nxt.rdata = {12'h000, st_r.tim_b.blank_cyc};
                ADDR_OFF_B: st_nxt.rdata = {12'h000, st_r.tim_b.off_cyc};
                ADDR_FD_B: st_nxt.rdata = {12'h000, st_r.tim_b.fd_cyc};
                ADDR_STATUS: st_nxt.rdata = {24'h000000, in_off_b, in_off_a, decay_sel,
                                             (st_r.wake_cnt >= WAKE_CNT), st_r.enabled, st_r.run, sr_n_s};
                default: begin
                    st_nxt.rdata = 32'h00000000;
                    st_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // Registered state; reset loads default timing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.sync1 <= 7'h07;
            st_r.sync2 <= 7'h07;
            st_r.tim_a <= '{blank_cyc: RST_BLANK, off_cyc: RST_OFF, fd_cyc: RST_FD};
            st_r.tim_b <= '{blank_cyc: RST_BLANK, off_cyc: RST_OFF, fd_cyc: RST_FD};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bus handshakes are registered flags
    assign s_axi_awready = !st_r.aw_held && aresetn;
    assign s_axi_wready = !st_r.w_held && aresetn;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid && aresetn;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign step_accept = st_r.step_accept;

    // ------------------------------------------------------------------
    // Bridges, each with its own timing registers
    // ------------------------------------------------------------------
    scc_bridge u_bridge_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(st_r.run),
        .polarity(polarity_a),
        .decay(decay_sel),
        .sync_rect(!sr_n_s || sr_float_s),
        .timing(st_r.tim_a),
        .current_sense_in(current_sense_in_a),
        .trip_level(trip_level_a),
        .zero_cross(zero_cross_a),
        .gate(gate_a_w),
        .in_off(in_off_a)
    );

    scc_bridge u_bridge_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(st_r.run),
        .polarity(polarity_b),
        .decay(decay_sel),
        .sync_rect(!sr_n_s || sr_float_s),
        .timing(st_r.tim_b),
        .current_sense_in(current_sense_in_b),
        .trip_level(trip_level_b),
        .zero_cross(zero_cross_b),
        .gate(gate_b_w),
        .in_off(in_off_b)
    );

    assign gate_a = gate_a_w;
    assign gate_b = gate_b_w;

    // Named reset budgets
    localparam logic [CNT_W-1:0] BUDGET_UNUSED = SLEEP_CNT | RESET_CNT;

endmodule : scc_top

// File: scc_motion_ctl.sv
// Motion controller model, one step per request
`timescale 1ns/10ps
module scc_motion_ctl #(
    parameter int HALF = 125
) (
    // Clock
    input wire logic aclk,
    // Request and step pin
    input wire logic go,
    output logic step_in,
    output logic busy
);
    int cnt_r = 0;
    initial {step_in, busy} = 2'b00;
    // HALF cycles high, HALF low: legal rate
    always @(posedge aclk) begin
        if (!busy && go) begin
            busy <= 1'b1;
            step_in <= 1'b1;
            cnt_r <= 0;
        end else if (busy) begin
            cnt_r <= cnt_r + 1;
            if (cnt_r == HALF - 1) step_in <= 1'b0;
            if (cnt_r == 2 * HALF - 1) busy <= 1'b0;
        end
    end
endmodule : scc_motion_ctl

// File: scc_top_props.sv
// Checker: gate safety and pin timing
`timescale 1ns/10ps
module scc_top_chk
    import scc_pkg::*;
#(
    parameter int ENABLE_CYCLES = 2500
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins and outputs watched
    input wire logic sleep_in_n,
    input wire logic output_enable_in_n,
    input wire logic device_reset_in_n,
    input wire logic step_in,
    input wire logic step_accept,
    input wire scc_gate_s gate_a,
    input wire scc_gate_s gate_b
);
    localparam int EN_LIM = ENABLE_CYCLES + 8;
    logic [15:0] dis_cnt_r;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Cycles spent disabled
    always_ff @(posedge aclk) begin
        if (!aresetn || !output_enable_in_n) dis_cnt_r <= 16'h0;
        else if (dis_cnt_r != 16'hffff) dis_cnt_r <= dis_cnt_r + 16'h1;
    end
    a_leg_no_shoot: assert property (!(gate_a.hs1 && gate_a.ls1) && !(gate_b.hs2 && gate_b.ls2))
        else $error("leg shoot through");
    a_dead_low_high: assert property ($fell(gate_a.ls1) |-> !gate_a.hs1 [*8])
        else $error("no dead time on leg one");
    a_dead_leg_two: assert property ($fell(gate_a.ls2) |-> !gate_a.hs2 [*8])
        else $error("no dead time on leg two");
    a_sleep_gates_off: assert property (!sleep_in_n [*6] |-> gate_a == 4'h0 && gate_b == 4'h0)
        else $error("gates on in sleep");
    a_reset_gates_off: assert property (!device_reset_in_n [*6] |-> gate_a == 4'h0 && gate_b == 4'h0)
        else $error("gates on in pin reset");
    a_enable_gates_off: assert property (dis_cnt_r > EN_LIM |-> gate_a == 4'h0 && gate_b == 4'h0)
        else $error("gates on while disabled");
    a_step_from_edge: assert property (step_accept |-> $past(step_in) && !$past(step_in, 2))
        else $error("accept without step edge");
    a_step_in_sleep: assert property (!sleep_in_n [*4] |-> !step_accept)
        else $error("step accepted in sleep");
endmodule : scc_top_chk

bind scc_top scc_top_chk #(.ENABLE_CYCLES(ENABLE_CYCLES)) chk_u (.aclk, .aresetn, .sleep_in_n,
    .output_enable_in_n, .device_reset_in_n, .step_in, .step_accept, .gate_a, .gate_b);

// File: test_stepper_chopper_control.sv
// Testbench for the stepper chopper control block
`timescale 1ns/10ps
module test_stepper_chopper_control
    import scc_pkg::*;
;
    logic aclk, aresetn, sleep_in_n, output_enable_in_n, device_reset_in_n, sync_rect_select_n, sync_rect_float;
    logic go, busy, step_in, step_accept, polarity_a, polarity_b, zero_cross_a, zero_cross_b;
    logic [LVL_W-1:0] current_sense_in_a, current_sense_in_b, trip;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    scc_decay_pin_s decay_pin;
    scc_gate_s gate_a, gate_b;
    int err_count = 0, cmp_count = 0, acc_cnt = 0;
    // Per case: pins, early and late gates
    logic [15:0] tbl [6] = '{16'h0355, 16'h0066, 16'h0165, 16'h0711, 16'h0b00, 16'h1165};

    scc_top #(.WAKE_CYCLES(50), .ENABLE_CYCLES(8)) dut_u (.aclk, .aresetn, .sleep_in_n, .output_enable_in_n,
        .device_reset_in_n, .sync_rect_select_n, .sync_rect_float, .decay_pin, .step_in, .current_sense_in_a,
        .current_sense_in_b, .trip_level_a(trip), .trip_level_b(trip), .polarity_a, .polarity_b, .zero_cross_a,
        .zero_cross_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_a, .gate_b, .step_accept);
    scc_motion_ctl #(.HALF(125)) ctl_u (.aclk, .go, .step_in, .busy);

    // ----------------------------------------------------------------
    // Clock, step counter, watchdog
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) if (step_accept === 1'b1) acc_cnt <= acc_cnt + 1;
    // Run needs ~6k cycles
    initial begin
        repeat (30000) @(posedge aclk);
        err_count++;
        report_and_stop;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // AW and W together; bready held to response
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 2'h0, s_axi_bresp);
        @(posedge aclk);
    endtask : axw
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
        @(posedge aclk);
    endtask : rchk
    task automatic wait_hs1(input logic v);
        for (int t = 0; t < 2000 && gate_a.hs1 !== v; t++) @(posedge aclk);
        chk("hs1", v, gate_a.hs1);
    endtask : wait_hs1
    task automatic step_once;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        @(posedge aclk);
        while (busy === 1'b1) @(posedge aclk);
    endtask : step_once
    task automatic report_and_stop;
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // Sense 8 against reference 0x40 is the trip edge
    initial begin
        {aresetn, go, sync_rect_select_n, sync_rect_float, zero_cross_a, zero_cross_b} = '0;
        {output_enable_in_n, polarity_b, current_sense_in_a, current_sense_in_b} = '0;
        {sleep_in_n, device_reset_in_n, polarity_a} = '1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
        {decay_pin, trip} = {2'b11, 8'h40};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(8'h00, 32'hfa, 2'h0);
        rchk(8'h04, 32'h1482, 2'h0);
        rchk(8'h08, 32'h520, 2'h0);
        rchk(8'h1c, 32'h0, 2'h2);
        axw(8'h00, 32'h28);
        axw(8'h04, 32'h12c);
        axw(8'h08, 32'h64);
        rchk(8'h04, 32'h12c, 2'h0);
        repeat (60) @(posedge aclk);
        chk("gate_a", 4'h9, gate_a);
        chk("gate_b", 4'h6, gate_b);
        current_sense_in_a <= 8'h07;
        repeat (400) @(posedge aclk);
        chk("gate_a", 4'h9, gate_a);
        current_sense_in_a <= 8'h08;
        for (int i = 0; i < 6; i++) begin
            {sync_rect_float, zero_cross_a, sync_rect_select_n, decay_pin} <= tbl[i][12:8];
            repeat (2) begin
                wait_hs1(1'b1);
                wait_hs1(1'b0);
            end
            repeat (60) @(posedge aclk);
            chk("decay_early", tbl[i][7:4], gate_a);
            repeat (140) @(posedge aclk);
            chk("decay_late", tbl[i][3:0], gate_a);
        end
        {zero_cross_a, current_sense_in_a} <= '0;
        step_once;
        chk("steps", 32'h1, acc_cnt);
        sleep_in_n <= 1'b0;
        repeat (10) @(posedge aclk);
        chk("sleep_gates", 8'h0, {gate_a, gate_b});
        step_once;
        sleep_in_n <= 1'b1;
        step_once;
        step_once;
        chk("steps", 32'h2, acc_cnt);
        device_reset_in_n <= 1'b0;
        repeat (10) @(posedge aclk);
        chk("reset_gates", 8'h0, {gate_a, gate_b});
        device_reset_in_n <= 1'b1;
        repeat (60) @(posedge aclk);
        chk("gate_a", 4'h9, gate_a);
        output_enable_in_n <= 1'b1;
        repeat (30) @(posedge aclk);
        chk("off_gates", 8'h0, {gate_a, gate_b});
        output_enable_in_n <= 1'b0;
        repeat (60) @(posedge aclk);
        chk("gate_a", 4'h9, gate_a);
        report_and_stop;
    end
endmodule : test_stepper_chopper_control
